// *** hw/sspt_consts.svh ***
// Purpose: constants for the serial slave port
// Assumes: included by bare name
// Notes: bit positions refer to the control and format words
`ifndef SSPT_CONSTS_SVH
`define SSPT_CONSTS_SVH
`define SSPT_ROLE_BIT 0
`define SSPT_PHASE_BIT 16
`define SSPT_POL_BIT 17
`define SSPT_PS_MSB 15
`define SSPT_PS_LSB 8
`define SSPT_WORD_BITS 16
`define SSPT_CNT_W 5
`define SSPT_CLK_PERIOD_NS 4
`define SSPT_MIN_SCLK_NS 25
`define SSPT_MIN_SCLK_CYC ((`SSPT_MIN_SCLK_NS + `SSPT_CLK_PERIOD_NS - 1) / `SSPT_CLK_PERIOD_NS)
`define SSPT_GCR_RESET 32'h0000_0000
`define SSPT_FMT_RESET 32'h0000_0000
`endif

// *** hw/sspt_pkg.sv ***
// Purpose: types for the serial slave port
// Assumes: nothing
// Notes: none
package sspt_pkg;
  typedef enum logic [1:0] {
    SSPT_IDLE = 2'b00,
    SSPT_SHIFT = 2'b01,
    SSPT_DONE = 2'b10
  } sspt_state_t;
endpackage

// *** hw/sspt_slave.sv ***
// Purpose: slave-mode serial port, 16-bit words, pin-driven shift clock
// Assumes: pins sampled by clock at 250 MHz, two flops deep
// Notes: pins are oversampled, so the serial clock must stay slow
// Functional notes
// R01 - slave role when control bit 0 is zero; clock taken from pin
// R02 - format bit 16 selects clock phase 0 or 1
// R03 - format bit 17 selects clock polarity, the idle level
// R04 - serial clock period at least (prescale+1) bus clocks, never below 25 ns
// R05 - host waits two serial clocks after select low before first edge
// R06 - host toggles select around every 16-bit word
// R07 - output changes after rising edge when polarity equals phase, else falling
// R08 - input sampled on falling edge when polarity equals phase, else rising
// R09 - msb first both lines; word complete after sixteenth sample edge
`timescale 1ns/1ns
`default_nettype none
`include "sspt_consts.svh"
module sspt_slave (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [31:0] spi_global_control_reg,
  input wire logic [31:0] spi_format_reg,
  input wire logic serial_clock_pin,
  input wire logic chip_select_n,
  input wire logic serial_input_line,
  output logic serial_output_line,
  output logic serial_output_en,
  input wire logic [15:0] tx_word,
  output logic tx_taken,
  output logic [15:0] rx_word,
  output logic rx_valid,
  output logic clock_too_fast
);
  logic [1:0] sclk_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] din_s_q;
  logic sclk_prev_q;
  logic [15:0] tx_sh_q;
  logic [15:0] rx_sh_q;
  logic [`SSPT_CNT_W-1:0] bit_cnt_q;
  logic [8:0] per_cnt_q;
  logic first_q;
  sspt_pkg::sspt_state_t state_q;
  logic slave_mode;
  logic pha;
  logic pol;
  logic [7:0] ps;
  logic rise;
  logic fall;
  logic sample_edge;
  logic shift_edge;
  logic lead_shift;
  logic sel;
  logic [8:0] min_cyc;

  // 25 ns floor rounded up to whole core cycles, never lets a fast clock by
  function automatic logic [8:0] min_period(input logic [7:0] p);
    logic [8:0] vclk;
    vclk = (p == 8'h00) ? 9'h002 : ({1'b0, p} + 9'h001);
    // 250 MHz core: each bus clock is one core cycle here
    if (vclk < 9'(`SSPT_MIN_SCLK_CYC))
      min_period = 9'(`SSPT_MIN_SCLK_CYC);
    else
      min_period = vclk;
  endfunction

  assign slave_mode = ~spi_global_control_reg[`SSPT_ROLE_BIT]; // R01
  assign pha = spi_format_reg[`SSPT_PHASE_BIT]; // R02
  assign pol = spi_format_reg[`SSPT_POL_BIT]; // R03
  assign ps = spi_format_reg[`SSPT_PS_MSB:`SSPT_PS_LSB];
  assign min_cyc = min_period(ps);
  assign sel = slave_mode & ~cs_s_q[1];
  assign rise = sclk_s_q[1] & ~sclk_prev_q;
  assign fall = ~sclk_s_q[1] & sclk_prev_q;
  // polarity and phase together pick the two edges
  assign sample_edge = (pol == pha) ? fall : rise; // R08
  assign shift_edge = (pol == pha) ? rise : fall; // R07
  // phase 0 moves data on the leading edge, which must show the msb
  assign lead_shift = ~pha; // R07

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sclk_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      din_s_q <= 2'h0;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      // second flop only is read; first is metastability guard
      // the third stage feeds the edge detector only
      sclk_s_q <= {sclk_s_q[0], serial_clock_pin}; // R01
      cs_s_q <= {cs_s_q[0], chip_select_n};
      din_s_q <= {din_s_q[0], serial_input_line};
      sclk_prev_q <= sclk_s_q[1];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state_q <= sspt_pkg::SSPT_IDLE;
    else if (!sel)
      state_q <= sspt_pkg::SSPT_IDLE; // R06
    else
    begin
      case (state_q)
        sspt_pkg::SSPT_IDLE:
          state_q <= sspt_pkg::SSPT_SHIFT;
        sspt_pkg::SSPT_SHIFT:
          if (sample_edge && bit_cnt_q == 5'(`SSPT_WORD_BITS - 1))
            state_q <= sspt_pkg::SSPT_DONE; // R09
        sspt_pkg::SSPT_DONE:
          state_q <= sspt_pkg::SSPT_DONE;
        default:
          state_q <= sspt_pkg::SSPT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      bit_cnt_q <= '0;
      rx_sh_q <= 16'h0000;
    end
    else if (state_q != sspt_pkg::SSPT_SHIFT)
      bit_cnt_q <= '0;
    else if (sample_edge)
    begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      rx_sh_q <= {rx_sh_q[14:0], din_s_q[1]}; // R09
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rx_word <= 16'h0000;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (state_q == sspt_pkg::SSPT_SHIFT && sample_edge &&
          bit_cnt_q == 5'(`SSPT_WORD_BITS - 1))
      begin
        rx_word <= {rx_sh_q[14:0], din_s_q[1]}; // R09
        rx_valid <= 1'b1;
      end
    end
  end

  // the skipped first shift keeps the msb on the line for the first sample;
  // the load sits one cycle after select, well inside the host's lead time
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tx_sh_q <= 16'h0000;
      first_q <= 1'b0;
      tx_taken <= 1'b0;
    end
    else
    begin
      tx_taken <= 1'b0;
      if (state_q == sspt_pkg::SSPT_IDLE && sel)
      begin
        tx_sh_q <= tx_word; // R09
        first_q <= lead_shift;
        tx_taken <= 1'b1;
      end
      else if (state_q == sspt_pkg::SSPT_SHIFT && shift_edge)
      begin
        if (first_q)
          first_q <= 1'b0;
        else
          tx_sh_q <= {tx_sh_q[14:0], 1'b0}; // R07
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      serial_output_line <= 1'b0;
      serial_output_en <= 1'b0;
    end
    else
    begin
      serial_output_line <= tx_sh_q[15]; // R09
      // enable lags select by one cycle; the msb follows one cycle later
      serial_output_en <= sel;
    end
  end

  // flags a serial clock faster than the prescale permits
  // sticky until reset, so a single glitch is not lost between polls
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      per_cnt_q <= 9'h1FF;
      clock_too_fast <= 1'b0;
    end
    else if (!sel)
      per_cnt_q <= 9'h1FF;
    else if (sample_edge)
    begin
      if (per_cnt_q < min_cyc)
        clock_too_fast <= 1'b1; // R04
      per_cnt_q <= 9'h001;
    end
    else if (per_cnt_q != 9'h1FF)
      per_cnt_q <= per_cnt_q + 9'h001;
  end
endmodule
`default_nettype wire

// *** tb/sspt_host.sv ***
// Purpose: host master model
// Assumes: half period >= 8 clocks
// Notes: drives at falling clock edges
`timescale 1ns/1ns
`default_nettype none
module sspt_host (
  input wire logic clock,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, input logic pol, pha,
    input int half, output logic [15:0] r);
    logic [3:0] idx;
    idx = pha ? 4'hE : 4'hF;
    // settle the clock at its idle level before select falls
    sclk = pol;
    mosi = w[15];
    repeat (half) @(negedge clock);
    cs_n = 1'b0;
    repeat (4 * half) @(negedge clock);
    for (int e = 0; e < 32; e++)
    begin
      sclk = ~sclk;
      if (sclk == (pol != pha))
        r = {r[14:0], miso};
      else
      begin
        mosi = w[idx];
        idx--;
      end
      repeat (half) @(negedge clock);
    end
    cs_n = 1'b1;
    repeat (2 * half) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// *** tb/sspt_slave_assertions.sv ***
// Purpose: port checker
// Assumes: pin half period 8 clocks
// Notes: edge window is 7 clocks
`timescale 1ns/1ns
`default_nettype none
module sspt_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [31:0] spi_global_control_reg,
  input wire logic [31:0] spi_format_reg,
  input wire logic serial_clock_pin,
  input wire logic chip_select_n,
  input wire logic serial_output_line,
  input wire logic serial_output_en,
  input wire logic tx_taken,
  input wire logic rx_valid,
  input wire logic clock_too_fast
);
  logic [7:0] h_q;
  logic sm;
  logic [6:0] tg;
  assign sm = spi_format_reg[17] == spi_format_reg[16];
  assign tg = h_q[6:0] ^ h_q[7:1];
  always_ff @(posedge clock) h_q <= {h_q[6:0], serial_clock_pin};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_sel;
    $fell(chip_select_n) && !spi_global_control_reg[0];
  endsequence
  property p_take;
    s_sel |-> ##[2:5] tx_taken;
  endproperty
  a_take: assert property (p_take) else $error("take");
  property p_role;
    spi_global_control_reg[0] [*2] |-> !serial_output_en && !rx_valid;
  endproperty
  a_role: assert property (p_role) else $error("role");
  property p_desel;
    chip_select_n [*6] |-> !serial_output_en;
  endproperty
  a_desel: assert property (p_desel) else $error("desel");
  property p_shift;
    serial_output_en && $past(serial_output_en, 3) && !chip_select_n &&
      $changed(serial_output_line) |-> |(tg & (sm ? h_q[6:0] : ~h_q[6:0]));
  endproperty
  a_shift: assert property (p_shift) else $error("shift");
  property p_smp;
    rx_valid |-> |(tg & (sm ? ~h_q[6:0] : h_q[6:0]));
  endproperty
  a_smp: assert property (p_smp) else $error("sample");
  property p_word;
    rx_valid |=> !rx_valid [*8];
  endproperty
  a_word: assert property (p_word) else $error("word");
  property p_fast;
    clock_too_fast |=> clock_too_fast;
  endproperty
  a_fast: assert property (p_fast) else $error("fast");
endmodule
bind sspt_slave sspt_chk i_chk (.clock, .rst_n, .spi_global_control_reg,
  .spi_format_reg, .serial_clock_pin, .chip_select_n, .serial_output_line,
  .serial_output_en, .tx_taken, .rx_valid, .clock_too_fast);
`default_nettype wire

// *** tb/sspt_slave_bench.sv ***
// Purpose: bench for the serial slave port
// Assumes: 250 MHz clock
// Notes: flag test third, flag is sticky; the reset test run last clears it
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) \
  check_count++; \
  if ((a) !== (b)) \
  begin \
    n_mismatch++; \
    $display("[ERR] %0t mismatch %0h %0h", $time, (a), (b)); \
  end
module sspt_slave_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] gcr = 32'h0000_0000;
  logic [31:0] fmt = 32'h0000_0000;
  logic [15:0] tx = 16'h0000;
  logic sclk, cs_n, mosi, miso, oe, tk, rxv, fast;
  logic [15:0] rxw, got, hr;
  int n_mismatch = 0;
  int check_count = 0;
  int n_rx = 0;
  int n_tk = 0;
  int n_oe = 0;
  int cyc = 0;
  always #2 clock = ~clock;
  sspt_host i_host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso));
  sspt_slave i_sspt_slave (.clock(clock), .rst_n(rst_n),
    .spi_global_control_reg(gcr), .spi_format_reg(fmt),
    .serial_clock_pin(sclk), .chip_select_n(cs_n), .serial_input_line(mosi),
    .serial_output_line(miso), .serial_output_en(oe), .tx_word(tx),
    .tx_taken(tk), .rx_word(rxw), .rx_valid(rxv), .clock_too_fast(fast));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(negedge clock)
  begin
    cyc++;
    if (rxv)
    begin
      got = rxw;
      n_rx++;
    end
    if (tk)
      n_tk++;
    if (oe)
      n_oe++;
    if (cyc == 20000)
    begin
      $display("[ERR] %0t timeout", $time);
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic t_modes;
    for (int m = 0; m < 4; m++)
    begin
      fmt = {14'h0000, m[1:0], 16'h0000};
      tx = 16'hC3A5 + m[15:0];
      i_host.xfer(16'h8E71 ^ tx, m[1], m[0], 8, hr);
      `CHK(got, 16'h8E71 ^ tx)
      `CHK(hr, tx)
      `CHK(n_rx, m + 1)
      `CHK(n_tk, m + 1)
    end
  endtask
  task automatic t_master;
    int oe0;
    gcr = 32'h0000_0001;
    oe0 = n_oe;
    i_host.xfer(16'h1234, 1'b0, 1'b0, 8, hr);
    `CHK(n_rx, 4)
    `CHK(n_tk, 4)
    `CHK(n_oe, oe0)
    `CHK(fast, 1'b0)
    gcr = 32'h0000_0000;
  endtask
  task automatic t_prescale;
    fmt = 32'h0000_1400;
    i_host.xfer(16'h0F0F, 1'b0, 1'b0, 8, hr);
    `CHK(fast, 1'b1)
  endtask
  task automatic t_reset;
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    `CHK(fast, 1'b0)
    `CHK(oe, 1'b0)
    fmt = 32'h0000_0000;
    tx = 16'h5A3C;
    i_host.xfer(16'h96E1, 1'b0, 1'b0, 8, hr);
    `CHK(got, 16'h96E1)
    `CHK(hr, 16'h5A3C)
    `CHK(n_rx, 6)
    `CHK(fast, 1'b0)
  endtask
  initial
  begin
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    t_modes();
    t_master();
    t_prescale();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
